// *** hdl/atc_pkg.sv ***
`default_nettype none

package atc_pkg;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam int         ADDR_W       = 8;
    localparam logic [7:0] OFS_TIMING   = 8'h00;
    localparam logic [7:0] OFS_CTRL     = 8'h04;
    localparam logic [7:0] OFS_STATUS   = 8'h08;
    localparam logic [7:0] OFS_MASK     = 8'h0C;
    localparam logic [7:0] OFS_RESULT   = 8'h10;
    localparam logic [7:0] TIMING_WMASK = 8'hBF;
    localparam logic [7:0] TIMING_RST   = 8'h00;
    localparam int         BIT_GO       = 0;
    localparam int         BIT_DONE     = 0;
    localparam logic [1:0] RESP_OKAY    = 2'h0;
    localparam logic [1:0] RESP_DECERR  = 2'h3;

    // ----------------------------------------------------------------
    // Converter timing
    // ----------------------------------------------------------------
    localparam int         RES_W        = 12;
    localparam int         RES_PAD      = 16 - RES_W;
    localparam logic [4:0] CONV_TADS    = 5'h0D;
    localparam int         INSTR_TOSC   = 4;
    localparam logic [2:0] INSTR_CNT    = 3'(INSTR_TOSC);

    typedef struct packed {
        logic       result_justify_sel;
        logic       rsvd;
        logic [2:0] acq_time_sel;
        logic [2:0] conv_clock_sel;
    } atc_timing_t;

    typedef enum logic [1:0] {
        ST_SAMPLE,
        ST_RCDLY,
        ST_ACQ,
        ST_CONV
    } atc_state_t;

    // Acquisition length in conversion-clock periods
    function automatic logic [4:0] acq_tads(input logic [2:0] code);
        case (code)
            3'h0:    acq_tads = 5'h00;
            3'h1:    acq_tads = 5'h02;
            3'h2:    acq_tads = 5'h04;
            3'h3:    acq_tads = 5'h06;
            3'h4:    acq_tads = 5'h08;
            3'h5:    acq_tads = 5'h0C;
            3'h6:    acq_tads = 5'h10;
            default: acq_tads = 5'h14;
        endcase
    endfunction

    // System-clock divisor for the conversion clock
    function automatic logic [6:0] div_ratio(input logic [2:0] code);
        case (code)
            3'h0:    div_ratio = 7'h02;
            3'h4:    div_ratio = 7'h04;
            3'h1:    div_ratio = 7'h08;
            3'h5:    div_ratio = 7'h10;
            3'h2:    div_ratio = 7'h20;
            3'h6:    div_ratio = 7'h40;
            default: div_ratio = 7'h02;
        endcase
    endfunction

    function automatic logic is_rc(input logic [2:0] code);
        is_rc = (code[1:0] == 2'h3);
    endfunction

    function automatic logic [15:0] justify(input logic       right,
                                           input logic [11:0] data);
        justify = right ? {{RES_PAD{1'b0}}, data} : {data, {RES_PAD{1'b0}}};
    endfunction

endpackage

`default_nettype wire

// *** hdl/atc_top.sv ***
// Functional notes
// - Format bit one right-justifies, zero left-justifies
// - Acquisition field picks 0..20 conversion-clock periods
// - Clock codes 000,100,001 divide by 2,4,8
// - Codes 101,010,110 divide by 16,32,64
// - Codes 111 and 011 select internal RC
// - RC source waits one instruction cycle first
// - Nonzero acquisition samples, then converts automatically
// - Zero acquisition converts at once; software waits
// - Completion clears go, sets flag, resumes sampling
//
// Our own choices: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module atc_top
(
    // Clock and reset
    input  wire logic                       aclk,
    input  wire logic                       aresetn,
    // AXI4-Lite write channels
    input  wire logic [atc_pkg::ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                       s_axi_awvalid,
    output logic                            s_axi_awready,
    input  wire logic [31:0]                s_axi_wdata,
    input  wire logic [3:0]                 s_axi_wstrb,
    input  wire logic                       s_axi_wvalid,
    output logic                            s_axi_wready,
    output logic [1:0]                      s_axi_bresp,
    output logic                            s_axi_bvalid,
    input  wire logic                       s_axi_bready,
    // AXI4-Lite read channels
    input  wire logic [atc_pkg::ADDR_W-1:0] s_axi_araddr,
    input  wire logic                       s_axi_arvalid,
    output logic                            s_axi_arready,
    output logic [31:0]                     s_axi_rdata,
    output logic [1:0]                      s_axi_rresp,
    output logic                            s_axi_rvalid,
    input  wire logic                       s_axi_rready,
    // Converter core
    input  wire logic [atc_pkg::RES_W-1:0]  conv_data,
    input  wire logic                       internal_rc_clock,
    output logic                            adc_sampling,
    output logic                            adc_converting,
    output logic                            adc_tad_tick,
    // Interrupt
    output logic                            irq
);

    // ----------------------------------------------------------------
    // Register state
    // ----------------------------------------------------------------
    atc_pkg::atc_timing_t adc_timing_control_ff;
    atc_pkg::atc_state_t  state_ff;
    atc_pkg::atc_state_t  nxt_state;
    logic                 int_status_ff;
    logic                 int_mask_ff;
    logic [15:0]          result_ff;
    logic                 done_ff;
    logic [6:0]           div_cnt_ff;
    logic [4:0]           tad_cnt_ff;
    logic [2:0]           dly_cnt_ff;
    logic                 rc_s1_ff;
    logic                 rc_s2_ff;
    logic                 rc_s3_ff;
    logic                 aw_held_ff;
    logic                 w_held_ff;
    logic [7:0]           awaddr_ff;
    logic [31:0]          wdata_ff;
    logic [3:0]           wstrb_ff;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = (a[7:2] == ofs[7:2]);
    endfunction

    function automatic logic mapped(input logic [7:0] a);
        mapped = hit(a, atc_pkg::OFS_TIMING) || hit(a, atc_pkg::OFS_CTRL)
              || hit(a, atc_pkg::OFS_STATUS) || hit(a, atc_pkg::OFS_MASK)
              || hit(a, atc_pkg::OFS_RESULT);
    endfunction

    wire logic       do_wr   = aw_held_ff && w_held_ff && !s_axi_bvalid;
    wire logic       wr_b0   = do_wr && wstrb_ff[0];
    wire logic [2:0] clk_sel = adc_timing_control_ff.conv_clock_sel;
    wire logic [2:0] acq_sel = adc_timing_control_ff.acq_time_sel;
    wire logic       rc_sel  = atc_pkg::is_rc(clk_sel);
    wire logic       running = (state_ff == atc_pkg::ST_ACQ) || (state_ff == atc_pkg::ST_CONV);
    wire logic       go_req  = wr_b0 && hit(awaddr_ff, atc_pkg::OFS_CTRL)
                               && wdata_ff[atc_pkg::BIT_GO] && (state_ff == atc_pkg::ST_SAMPLE);
    wire logic       rc_edge = rc_s2_ff && !rc_s3_ff;
    wire logic       conv_end = (state_ff == atc_pkg::ST_CONV) && adc_tad_tick
                                && (tad_cnt_ff == atc_pkg::CONV_TADS - 5'h01);
    wire logic [15:0] just_val = atc_pkg::justify(adc_timing_control_ff.result_justify_sel,
                                                  conv_data);

    // ----------------------------------------------------------------
    // AXI4-Lite write path
    // ----------------------------------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held_ff    <= 1'b0;
            w_held_ff     <= 1'b0;
            awaddr_ff     <= 8'h00;
            wdata_ff      <= 32'h0000_0000;
            wstrb_ff      <= 4'h0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= atc_pkg::RESP_OKAY;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_held_ff    <= 1'b1;
                awaddr_ff     <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_held_ff    <= 1'b1;
                wdata_ff     <= s_axi_wdata;
                wstrb_ff     <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (do_wr)
            begin
                aw_held_ff   <= 1'b0;
                w_held_ff    <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= mapped(awaddr_ff) ? atc_pkg::RESP_OKAY : atc_pkg::RESP_DECERR;
            end
            if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // AXI4-Lite read path
    // ----------------------------------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= atc_pkg::RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rresp   <= mapped(s_axi_araddr) ? atc_pkg::RESP_OKAY : atc_pkg::RESP_DECERR;
            s_axi_rdata   <= 32'h0000_0000;
            if (hit(s_axi_araddr, atc_pkg::OFS_TIMING))
                s_axi_rdata[7:0] <= adc_timing_control_ff;
            if (hit(s_axi_araddr, atc_pkg::OFS_CTRL))
                s_axi_rdata[atc_pkg::BIT_GO] <= (state_ff != atc_pkg::ST_SAMPLE);
            if (hit(s_axi_araddr, atc_pkg::OFS_STATUS))
                s_axi_rdata[atc_pkg::BIT_DONE] <= int_status_ff;
            if (hit(s_axi_araddr, atc_pkg::OFS_MASK))
                s_axi_rdata[atc_pkg::BIT_DONE] <= int_mask_ff;
            if (hit(s_axi_araddr, atc_pkg::OFS_RESULT))
                s_axi_rdata[15:0] <= result_ff;
        end
        else if (s_axi_rvalid && s_axi_rready)
        begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // Control registers and interrupt
    // ----------------------------------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            adc_timing_control_ff <= atc_pkg::TIMING_RST;
            int_mask_ff           <= 1'b0;
            int_status_ff         <= 1'b0;
            irq                   <= 1'b0;
        end
        else
        begin
            if (wr_b0 && hit(awaddr_ff, atc_pkg::OFS_TIMING))
                adc_timing_control_ff <= wdata_ff[7:0] & atc_pkg::TIMING_WMASK;
            if (wr_b0 && hit(awaddr_ff, atc_pkg::OFS_MASK))
                int_mask_ff <= wdata_ff[atc_pkg::BIT_DONE];
            if (conv_end)
                int_status_ff <= 1'b1;
            else if (wr_b0 && hit(awaddr_ff, atc_pkg::OFS_STATUS) && wdata_ff[atc_pkg::BIT_DONE])
                int_status_ff <= 1'b0;
            irq <= (int_status_ff || conv_end) && int_mask_ff;
        end
    end

    // ----------------------------------------------------------------
    // Conversion clock source
    // ----------------------------------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rc_s1_ff <= 1'b0;
            rc_s2_ff <= 1'b0;
            rc_s3_ff <= 1'b0;
        end
        else
        begin
            rc_s1_ff <= internal_rc_clock;
            rc_s2_ff <= rc_s1_ff;
            rc_s3_ff <= rc_s2_ff;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            div_cnt_ff   <= 7'h00;
            adc_tad_tick <= 1'b0;
        end
        else if (!running)
        begin
            div_cnt_ff   <= 7'h00;
            adc_tad_tick <= 1'b0;
        end
        else if (rc_sel)
        begin
            div_cnt_ff   <= 7'h00;
            adc_tad_tick <= rc_edge;
        end
        else if (div_cnt_ff >= atc_pkg::div_ratio(clk_sel) - 7'h01)
        begin
            div_cnt_ff   <= 7'h00;
            adc_tad_tick <= 1'b1;
        end
        else
        begin
            div_cnt_ff   <= div_cnt_ff + 7'h01;
            adc_tad_tick <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Sequencer
    // ----------------------------------------------------------------
    always_comb
    begin
        nxt_state = state_ff;
        unique case (state_ff)
            atc_pkg::ST_SAMPLE:
                if (go_req)
                    nxt_state = rc_sel ? atc_pkg::ST_RCDLY
                              : (acq_sel == 3'h0) ? atc_pkg::ST_CONV : atc_pkg::ST_ACQ;
            atc_pkg::ST_RCDLY:
                if (dly_cnt_ff == atc_pkg::INSTR_CNT - 3'h1)
                    nxt_state = (acq_sel == 3'h0) ? atc_pkg::ST_CONV : atc_pkg::ST_ACQ;
            atc_pkg::ST_ACQ:
                if (adc_tad_tick && tad_cnt_ff >= atc_pkg::acq_tads(acq_sel) - 5'h01)
                    nxt_state = atc_pkg::ST_CONV;
            atc_pkg::ST_CONV:
                if (conv_end)
                    nxt_state = atc_pkg::ST_SAMPLE;
        endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state_ff       <= atc_pkg::ST_SAMPLE;
            tad_cnt_ff     <= 5'h00;
            dly_cnt_ff     <= 3'h0;
            adc_sampling   <= 1'b1;
            adc_converting <= 1'b0;
        end
        else
        begin
            state_ff       <= nxt_state;
            adc_sampling   <= (nxt_state != atc_pkg::ST_CONV);
            adc_converting <= (nxt_state == atc_pkg::ST_CONV);
            dly_cnt_ff     <= (state_ff == atc_pkg::ST_RCDLY) ? dly_cnt_ff + 3'h1 : 3'h0;
            if (nxt_state != state_ff)
                tad_cnt_ff <= 5'h00;
            else if (adc_tad_tick)
                tad_cnt_ff <= tad_cnt_ff + 5'h01;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            result_ff <= 16'h0000;
            done_ff   <= 1'b0;
        end
        else
        begin
            done_ff <= conv_end;
            if (conv_end)
                result_ff <= just_val;
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    logic [6:0] gap_ff;
    logic       gap_ok_ff;
    logic [4:0] acq_seen_ff;
    wire logic  in_rcdly = (state_ff == atc_pkg::ST_RCDLY);

    always_ff @(posedge aclk)
    begin
        if (!aresetn || !running || rc_sel || (wr_b0 && hit(awaddr_ff, atc_pkg::OFS_TIMING)))
            gap_ok_ff <= 1'b0;
        else if (adc_tad_tick)
            gap_ok_ff <= 1'b1;
        gap_ff      <= adc_tad_tick ? 7'h01 : gap_ff + 7'h01;
        acq_seen_ff <= (state_ff != atc_pkg::ST_ACQ) ? 5'h00
                     : acq_seen_ff + {4'h0, adc_tad_tick};
    end

    justify_result_a: assert property (done_ff |-> result_ff == $past(just_val))
        else $error("result justification wrong");
    acq_length_a: assert property ($fell(state_ff == atc_pkg::ST_ACQ)
                                   |-> acq_seen_ff == atc_pkg::acq_tads(acq_sel))
        else $error("acquisition length wrong");
    div_spacing_a: assert property (adc_tad_tick && gap_ok_ff && !rc_sel
                                    |-> gap_ff == atc_pkg::div_ratio(clk_sel))
        else $error("divider spacing wrong");
    div_large_a: assert property (adc_tad_tick && gap_ok_ff
                                  && (clk_sel == 3'h5 || clk_sel == 3'h2 || clk_sel == 3'h6)
                                  |-> gap_ff >= 7'h10)
        else $error("large divider spacing wrong");
    rc_tick_a: assert property (adc_tad_tick && rc_sel |-> $past(rc_edge))
        else $error("rc tick without rc edge");
    rc_delay_a: assert property ($rose(in_rcdly) |-> in_rcdly [*4] ##1 !in_rcdly)
        else $error("rc start delay wrong");
    auto_conv_a: assert property (go_req && acq_sel != 3'h0 && !rc_sel
                                  |=> adc_sampling && state_ff == atc_pkg::ST_ACQ)
        else $error("no automatic acquisition");
    acq_exit_a: assert property ($fell(state_ff == atc_pkg::ST_ACQ) |-> adc_converting)
        else $error("acquisition did not end in conversion");
    go_now_a: assert property (go_req && acq_sel == 3'h0 && !rc_sel |=> adc_converting)
        else $error("manual start not immediate");
    done_seq_a: assert property (done_ff |-> state_ff == atc_pkg::ST_SAMPLE
                                 && int_status_ff && adc_sampling)
        else $error("completion effects missing");
    rsvd_zero_a: assert property (adc_timing_control_ff.rsvd == 1'b0)
        else $error("reserved bit set");
    irq_level_a: assert property (irq == $past((int_status_ff || conv_end) && int_mask_ff))
        else $error("interrupt level wrong");

    conv_done_c: cover property (done_ff);
    rc_path_c: cover property ($rose(in_rcdly) ##[1:1000] done_ff);
    irq_set_c: cover property ($rose(irq));

endmodule

`default_nettype wire

// *** testbench/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    // ----------------------------------------------------------------
    // Stimulus and observation
    // ----------------------------------------------------------------
    logic                          aclk, aresetn, rc_clk;
    logic [atc_pkg::ADDR_W-1:0]    awaddr, araddr;
    logic                          awvalid, awready, wvalid, wready, bvalid, bready;
    logic                          arvalid, arready, rvalid, rready;
    logic [31:0]                   wdata, rdata, e;
    logic [3:0]                    wstrb;
    logic [1:0]                    bresp, rresp;
    logic [atc_pkg::RES_W-1:0]     conv_data;
    logic                          sampling, converting, tick, irq, first_pend, was_conv;
    logic [15:0]                   seed;
    logic [7:0]                    tm;
    logic [1:0]                    wq[$];
    logic [33:0]                   rq[$];
    logic [31:0]                   cq[$];
    int                            bad_count, comparisons, cyc, go_cyc, done_n, n, d0;
    int                            acq_n, cnv_n, last_t, gap, first_d;
    int                            acq_tab [8] = '{0, 2, 4, 6, 8, 12, 16, 20};
    // Internal RC entries hold the RC period in system clocks
    int                            div_tab [8] = '{2, 8, 32, 5, 4, 16, 64, 5};

    atc_top i_atc_top
    (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .conv_data(conv_data),
        .internal_rc_clock(rc_clk), .adc_sampling(sampling), .adc_converting(converting),
        .adc_tad_tick(tick), .irq(irq)
    );

    initial
    begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end

    // Free-running RC oscillator, phase unrelated to aclk
    initial
    begin
        rc_clk = 1'b0;
        #1.3;
        forever #10 rc_clk = ~rc_clk;
    end

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    task automatic check(input string name, input logic [33:0] seen, input logic [33:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic test_done();
        $display("Mismatches %0d, comparisons %0d", bad_count, comparisons);
        if (bad_count == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic hang(input string name);
        bad_count++;
        $display("ERROR %s expected response seen timeout", name);
        test_done();
    endtask

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                          input logic [1:0] r);
        int k;
        k = 0;
        wq.push_back(r);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(posedge aclk);
            k++;
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end
        while (!bvalid && k < 200);
        bready <= 1'b0;
        if (k >= 200) hang("bvalid");
        @(posedge aclk);
    endtask

    task automatic axi_rd(input logic [7:0] a, input logic [33:0] x);
        int k;
        k = 0;
        rq.push_back(x);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(posedge aclk);
            k++;
            if (arready) arvalid <= 1'b0;
        end
        while (!rvalid && k < 200);
        rready <= 1'b0;
        if (k >= 200) hang("rvalid");
        @(posedge aclk);
    endtask

    // ----------------------------------------------------------------
    // Output monitor: pops the oldest note whenever a result appears
    // ----------------------------------------------------------------
    always @(posedge aclk)
    begin
        cyc <= cyc + 1;
        if (bvalid && bready) check("bresp", 34'(bresp), 34'(wq.pop_front()));
        if (rvalid && rready) check("rdata", {rresp, rdata}, rq.pop_front());
        if (tick)
        begin
            if (converting) cnv_n++;
            else acq_n++;
            gap = cyc - last_t;
            last_t = cyc;
            if (first_pend)
            begin
                first_d = cyc - go_cyc;
                first_pend = 1'b0;
            end
        end
        if (was_conv && !converting)
        begin
            e = cq.pop_front();
            check("acq_ticks", 34'(acq_n), 34'(e[31:24]));
            check("conv_ticks", 34'(cnv_n), 34'(e[23:16]));
            check("tick_gap", 34'(gap), 34'(e[15:8]));
            check("rc_delay", 34'(first_d >= int'(e[7:0])), 34'h1);
            check("sampling", 34'(sampling), 34'h1);
            acq_n = 0;
            cnv_n = 0;
            done_n <= done_n + 1;
        end
        was_conv = converting;
    end

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial
    begin
        {aresetn, awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
        {araddr, arvalid, rready, conv_data, first_pend, was_conv} = '0;
        {bad_count, comparisons, cyc, go_cyc, done_n, acq_n, cnv_n, last_t, gap} = '0;
        first_d = 0;
        seed = 16'h002A;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        axi_rd(atc_pkg::OFS_TIMING, {atc_pkg::RESP_OKAY, 32'h00000000});
        axi_rd(atc_pkg::OFS_CTRL, {atc_pkg::RESP_OKAY, 32'h00000000});
        axi_wr(atc_pkg::OFS_TIMING, 32'h000000FF, 4'hF, atc_pkg::RESP_OKAY);
        axi_rd(atc_pkg::OFS_TIMING, {atc_pkg::RESP_OKAY, 32'h000000BF});
        axi_wr(atc_pkg::OFS_TIMING, 32'h00000000, 4'h0, atc_pkg::RESP_OKAY);
        axi_rd(atc_pkg::OFS_TIMING, {atc_pkg::RESP_OKAY, 32'h000000BF});
        axi_wr(8'h14, 32'h000000FF, 4'hF, atc_pkg::RESP_DECERR);
        axi_rd(8'h14, {atc_pkg::RESP_DECERR, 32'h00000000});
        // Every clock code and every acquisition code once, justification alternating
        for (int i = 0; i < 8; i++)
        begin
            tm = {i[0], 1'b0, 3'(7 - i), 3'(i)};
            seed = lfsr(seed);
            conv_data <= seed[11:0];
            axi_wr(atc_pkg::OFS_MASK, 32'(i != 3), 4'hF, atc_pkg::RESP_OKAY);
            axi_wr(atc_pkg::OFS_TIMING, 32'(tm), 4'hF, atc_pkg::RESP_OKAY);
            cq.push_back({8'(acq_tab[7 - i]), 8'h0D, 8'(div_tab[i]),
                          (i % 4 == 3) ? 8'(atc_pkg::INSTR_TOSC + 2) : 8'h00});
            go_cyc = cyc;
            first_pend = 1'b1;
            d0 = done_n;
            axi_wr(atc_pkg::OFS_CTRL, 32'h00000001, 4'hF, atc_pkg::RESP_OKAY);
            n = 0;
            while (!converting && n < 3000)
            begin
                @(posedge aclk);
                n++;
            end
            // A second go while busy must not start another conversion
            axi_wr(atc_pkg::OFS_CTRL, 32'h00000001, 4'hF, atc_pkg::RESP_OKAY);
            axi_rd(atc_pkg::OFS_CTRL, {atc_pkg::RESP_OKAY, 32'h00000001});
            while (done_n == d0 && n < 3000)
            begin
                @(posedge aclk);
                n++;
            end
            if (n >= 3000) hang("conversion");
            axi_rd(atc_pkg::OFS_CTRL, {atc_pkg::RESP_OKAY, 32'h00000000});
            axi_rd(atc_pkg::OFS_RESULT, {atc_pkg::RESP_OKAY, i[0] ? {20'h00000, seed[11:0]}
                                         : {16'h0000, seed[11:0], 4'h0}});
            axi_rd(atc_pkg::OFS_STATUS, {atc_pkg::RESP_OKAY, 32'h00000001});
            check("irq", 34'(irq), 34'(i != 3));
            axi_wr(atc_pkg::OFS_STATUS, 32'h00000001, 4'hF, atc_pkg::RESP_OKAY);
            axi_rd(atc_pkg::OFS_STATUS, {atc_pkg::RESP_OKAY, 32'h00000000});
            check("irq", 34'(irq), 34'h0);
        end
        test_done();
    end
endmodule

`default_nettype wire
